// >>> hdl/print_sequence_controller.sv
// Print engine period sequencer with sleep control
// Functional notes
// R01 - Warm-up on power-on, door close or sleep exit, until ready
// R02 - Warm-up heats fuser, detects parts, homes belt, cleans toner
// R03 - Standby after warm-up or last rotation until print command
// R04 - In standby, sleep command sleeps, calibration command calibrates
// R05 - Initial rotation from print command until first sheet picked
// R06 - Initial rotation enables supply, scanner, shutter, cartridges, fuser
// R07 - Printing follows initial rotation until last sheet fused
// R08 - Printing forms, transfers and fuses the image
// R09 - Last rotation follows printing until main motor stops
// R10 - Last rotation delivers sheet, stops supply, scanner, fuser
// R11 - Pending print command goes from last rotation to initial rotation
// R12 - Signal formatter for image data only after synchronisation
// R13 - Sleep after adjustable idle time, enabled, default thirty minutes; the code has no default and takes the time from i_sleep_minutes
// R14 - Asleep: backlight off, settings kept
// R15 - Jobs, buttons, covers, trays or test switch wake to warm-up
// R16 - Error display wins over sleep display; sleep timing unchanged
// R17 - One current period held in a register; reset gives warm-up
`timescale 1ns/1ps
`include "psc_cfg.svh"
module print_sequence_controller
   import psc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_door_closed,
   input wire logic i_engine_ready,
   input wire logic i_print_cmd,
   input wire logic i_sleep_cmd,
   input wire logic i_calib_cmd,
   input wire logic i_calib_done,
   input wire logic i_first_pick,
   input wire logic i_last_fused,
   input wire logic i_motor_stopped,
   input wire logic i_image_synced,
   input wire logic i_sleep_enable,
   input wire logic [15:0] i_sleep_minutes,
   input wire logic i_wake_event,
   input wire logic i_error_active,
   output logic [2:0] o_period,
   output logic o_fuser_heat,
   output logic o_detect_parts,
   output logic o_home_belt,
   output logic o_clean_toner,
   output logic o_hv_on,
   output logic o_scanner_on,
   output logic o_shutter_open,
   output logic o_clean_window,
   output logic o_cart_engaged,
   output logic o_form_image,
   output logic o_deliver,
   output logic o_calibrating,
   output logic o_image_req,
   output logic o_backlight_on,
   output logic o_show_sleep,
   output logic o_show_error
);
   // --------------------------------------------------------------
   // Period state
   // --------------------------------------------------------------
   period_t st_r, st_nxt;
   logic pend_r, pend_nxt;
   logic cal_r, cal_nxt;
   logic door_r;
   idle_if il();

   idle_timer u_idle (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .lnk(il)
   );

   // Idle means nothing in flight; a print or calibration command or a wake event restarts the count
   assign il.enable = i_sleep_enable && (st_r == ST_STANDBY) && !cal_r;
   assign il.clear = i_print_cmd || i_wake_event || i_calib_cmd; // R13
   assign il.minutes = i_sleep_minutes;

   always_comb begin
      st_nxt = st_r;
      pend_nxt = pend_r;
      cal_nxt = cal_r;
      // A print arriving mid-calibration is held rather than lost
      if (i_print_cmd && (st_r != ST_STANDBY || cal_r))
         pend_nxt = 1'b1; // R05
      unique case (st_r)
         ST_WARMUP: begin
            if (i_engine_ready)
               st_nxt = ST_STANDBY; // R01 R03
         end
         ST_STANDBY: begin
            if (cal_r) begin
               if (i_calib_done)
                  cal_nxt = 1'b0; // R04
            end else if (i_print_cmd || pend_r) begin
               st_nxt = ST_INIT_ROT; // R05
               pend_nxt = 1'b0;
            end else if (i_calib_cmd) begin
               cal_nxt = 1'b1; // R04
            end else if (i_sleep_cmd || il.expired) begin
               st_nxt = ST_SLEEP; // R04 R13
            end
         end
         ST_INIT_ROT: begin
            if (i_first_pick)
               st_nxt = ST_PRINTING; // R05 R07
         end
         ST_PRINTING: begin
            if (i_last_fused)
               st_nxt = ST_LAST_ROT; // R07 R09
         end
         ST_LAST_ROT: begin
            if (i_motor_stopped) begin
               if (pend_r || i_print_cmd) begin
                  st_nxt = ST_INIT_ROT; // R11
                  pend_nxt = 1'b0;
               end else begin
                  st_nxt = ST_STANDBY; // R03
               end
            end
         end
         ST_SLEEP: begin
            if (i_wake_event || i_print_cmd)
               st_nxt = ST_WARMUP; // R15
         end
      endcase
      // Door closing restarts warm-up from any period
      if (i_door_closed && !door_r)
         st_nxt = ST_WARMUP; // R01
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_r <= ST_WARMUP; // R17
         pend_r <= 1'b0;
         cal_r <= 1'b0;
         door_r <= 1'b1;
      end else begin
         st_r <= st_nxt;
         pend_r <= pend_nxt;
         cal_r <= cal_nxt;
         door_r <= i_door_closed;
      end
   end

   // --------------------------------------------------------------
   // Subsystem controls, registered from the next period
   // --------------------------------------------------------------
   logic [16:0] out_nxt, out_r;
   logic in_ir, in_pr, in_lr, in_wu, in_sl;
   always_comb begin
      in_wu = (st_nxt == ST_WARMUP);
      in_ir = (st_nxt == ST_INIT_ROT);
      in_pr = (st_nxt == ST_PRINTING);
      in_lr = (st_nxt == ST_LAST_ROT);
      in_sl = (st_nxt == ST_SLEEP);
      out_nxt[0] = in_wu || in_ir || in_pr; // R02 R06 R10
      out_nxt[1] = in_wu; // R02
      out_nxt[2] = in_wu; // R02
      out_nxt[3] = in_wu; // R02
      out_nxt[4] = in_ir || in_pr; // R06 R10
      out_nxt[5] = in_ir || in_pr; // R06 R10
      out_nxt[6] = in_ir || in_pr; // R06 R10
      out_nxt[7] = in_ir || in_lr; // R06 R10
      out_nxt[8] = in_ir || in_pr; // R06 R10
      out_nxt[9] = in_pr; // R08
      out_nxt[10] = in_lr; // R10
      out_nxt[11] = cal_nxt;
      // Data request only once paper and image paths are aligned
      out_nxt[12] = in_pr && i_image_synced; // R12
      out_nxt[13] = !in_sl; // R14
      out_nxt[14] = in_sl && !i_error_active; // R16
      out_nxt[15] = i_error_active; // R16
      out_nxt[16] = 1'b0;
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst)
         out_r <= 17'h0200F; // R02
      else
         out_r <= out_nxt;
   end

   assign o_period = st_r;
   assign o_fuser_heat = out_r[0];
   assign o_detect_parts = out_r[1];
   assign o_home_belt = out_r[2];
   assign o_clean_toner = out_r[3];
   assign o_hv_on = out_r[4];
   assign o_scanner_on = out_r[5];
   assign o_shutter_open = out_r[6];
   assign o_clean_window = out_r[7];
   assign o_cart_engaged = out_r[8];
   assign o_form_image = out_r[9];
   assign o_deliver = out_r[10];
   assign o_calibrating = out_r[11];
   assign o_image_req = out_r[12];
   assign o_backlight_on = out_r[13];
   assign o_show_sleep = out_r[14];
   assign o_show_error = out_r[15];

   // --------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------
   // Door closing seen as a rising level against the last cycle
   logic door_rise;
   assign door_rise = i_door_closed && !door_r;

   // Standby with nothing in flight and no door restart
   sequence s_standby_period_free;
      st_r == ST_STANDBY && !cal_r && !pend_r && !i_print_cmd && !door_rise;
   endsequence
   sequence s_wake;
      st_r == ST_SLEEP && (i_wake_event || i_print_cmd) && !i_door_closed;
   endsequence
   a_reset_period: assert property (@(posedge i_clk)
      $rose(i_nrst) |-> st_r == ST_WARMUP) // R17
      else $error("period not warm-up after reset");
   a_sleep_wake: assert property (@(posedge i_clk) disable iff (!i_nrst)
      s_wake |=> st_r == ST_WARMUP) // R15
      else $error("sleep did not wake to warm-up");
   a_image_gate: assert property (@(posedge i_clk) disable iff (!i_nrst)
      o_image_req |-> $past(i_image_synced) && st_r == ST_PRINTING) // R12
      else $error("image request without sync");
   a_lastrot_chain: assert property (@(posedge i_clk) disable iff (!i_nrst)
      st_r == ST_LAST_ROT && i_motor_stopped && pend_r && !i_door_closed
      |=> st_r == ST_INIT_ROT) // R11
      else $error("pending print lost after last rotation");
   a_backlight_off: assert property (@(posedge i_clk) disable iff (!i_nrst)
      st_r == ST_SLEEP |-> !o_backlight_on) // R14
      else $error("backlight on in sleep");
   a_error_prio: assert property (@(posedge i_clk) disable iff (!i_nrst)
      o_show_sleep |-> !o_show_error) // R16
      else $error("sleep shown over error");
   a_print_path: assert property (@(posedge i_clk) disable iff (!i_nrst)
      st_r == ST_INIT_ROT && i_first_pick && !i_door_closed
      |=> st_r == ST_PRINTING ##0 o_form_image) // R07
      else $error("printing not entered");
   a_init_outs: assert property (@(posedge i_clk) disable iff (!i_nrst)
      st_r == ST_INIT_ROT |-> o_hv_on && o_scanner_on && o_cart_engaged) // R06
      else $error("initial rotation outputs off");
   a_warm_ready: assert property (@(posedge i_clk) disable iff (!i_nrst)
      st_r == ST_WARMUP && i_engine_ready && !door_rise
      |=> st_r == ST_STANDBY) // R01
      else $error("warm-up did not end in standby");
   a_warm_outs: assert property (@(posedge i_clk) disable iff (!i_nrst)
      st_r == ST_WARMUP |-> o_fuser_heat && o_detect_parts
      && o_home_belt && o_clean_toner) // R02
      else $error("warm-up jobs not running");
   a_door_warm: assert property (@(posedge i_clk) disable iff (!i_nrst)
      door_rise |=> st_r == ST_WARMUP ##0 o_home_belt) // R01
      else $error("door close did not restart warm-up");
   a_standby_period_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
      s_standby_period_free ##0 !i_calib_cmd && !i_sleep_cmd && !il.expired
      |=> st_r == ST_STANDBY) // R03
      else $error("standby left without a cause");
   a_standby_period_sleep: assert property (@(posedge i_clk) disable iff (!i_nrst)
      s_standby_period_free ##0 !i_calib_cmd && i_sleep_cmd
      |=> st_r == ST_SLEEP) // R04
      else $error("sleep command ignored");
   a_calib_start: assert property (@(posedge i_clk) disable iff (!i_nrst)
      s_standby_period_free ##0 i_calib_cmd
      |=> o_calibrating && st_r == ST_STANDBY) // R04
      else $error("calibration not started");
   a_print_start: assert property (@(posedge i_clk) disable iff (!i_nrst)
      st_r == ST_STANDBY && !cal_r && i_print_cmd && !door_rise
      |=> st_r == ST_INIT_ROT) // R05
      else $error("print command did not start rotation");
   a_calib_print: assert property (@(posedge i_clk) disable iff (!i_nrst)
      st_r == ST_STANDBY && cal_r && i_print_cmd |=> pend_r) // R05
      else $error("print during calibration lost");
   a_print_outs: assert property (@(posedge i_clk) disable iff (!i_nrst)
      st_r == ST_PRINTING |-> o_form_image && o_hv_on && o_fuser_heat
      && !o_deliver) // R08
      else $error("printing outputs wrong");
   a_last_entry: assert property (@(posedge i_clk) disable iff (!i_nrst)
      st_r == ST_PRINTING && i_last_fused && !door_rise
      |=> st_r == ST_LAST_ROT ##0 o_deliver) // R09
      else $error("last rotation not entered");
   a_last_outs: assert property (@(posedge i_clk) disable iff (!i_nrst)
      st_r == ST_LAST_ROT |-> !o_hv_on && !o_scanner_on && !o_shutter_open
      && !o_cart_engaged && !o_fuser_heat && o_clean_window) // R10
      else $error("last rotation outputs wrong");
   a_last_done: assert property (@(posedge i_clk) disable iff (!i_nrst)
      st_r == ST_LAST_ROT && i_motor_stopped && !pend_r && !i_print_cmd
      && !door_rise |=> st_r == ST_STANDBY) // R03
      else $error("last rotation did not return to standby");
   // Idle expiry follows the same priority as a sleep command
   a_idle_sleep: assert property (@(posedge i_clk) disable iff (!i_nrst)
      s_standby_period_free ##0 !i_calib_cmd && il.expired
      |=> st_r == ST_SLEEP) // R13
      else $error("idle expiry did not sleep");
   a_backlight_on: assert property (@(posedge i_clk) disable iff (!i_nrst)
      st_r != ST_SLEEP |-> o_backlight_on) // R14
      else $error("backlight off while awake");
   a_error_shown: assert property (@(posedge i_clk) disable iff (!i_nrst)
      o_show_error == $past(i_error_active)) // R16
      else $error("error display not following error");
   a_sleep_shown: assert property (@(posedge i_clk) disable iff (!i_nrst)
      st_r == ST_SLEEP && !$past(i_error_active) |-> o_show_sleep) // R16
      else $error("sleep indication missing");
   a_image_off: assert property (@(posedge i_clk) disable iff (!i_nrst)
      st_r != ST_PRINTING |-> !o_image_req) // R12
      else $error("image request outside printing");
endmodule

// >>> inc/psc_cfg.svh
// Constants for the print sequence controller
`ifndef PSC_CFG_SVH
`define PSC_CFG_SVH
`define PSC_CLK_HZ 20000000
`define PSC_IDLE_MIN_DEF 30
`define PSC_CYC_PER_MIN (`PSC_CLK_HZ * 60)
`define PSC_IDLE_W 16
`define PSC_CNT_W 40
`endif

// >>> inc/psc_pkg.sv
// Types for the print sequence controller
package psc_pkg;
   typedef enum logic [2:0] {
      ST_WARMUP = 3'h0,
      ST_STANDBY = 3'h1,
      ST_INIT_ROT = 3'h3,
      ST_PRINTING = 3'h2,
      ST_LAST_ROT = 3'h6,
      ST_SLEEP = 3'h4
   } period_t;
endpackage

// >>> inc/idle_if.sv
// Idle timer link between sequencer and timer
`timescale 1ns/1ps
interface idle_if;
   logic clear;
   logic enable;
   logic [15:0] minutes;
   logic expired;
   modport seq (output clear, output enable, output minutes, input expired);
   modport tmr (input clear, input enable, input minutes, output expired);
endinterface

// >>> hdl/idle_timer.sv
// Idle timer counting minutes of inactivity
`timescale 1ns/1ps
`include "psc_cfg.svh"
module idle_timer (
   input wire logic i_clk,
   input wire logic i_nrst,
   idle_if.tmr lnk
);
   logic [39:0] cyc_r, cyc_nxt;
   logic [15:0] min_r, min_nxt;
   logic exp_r, exp_nxt;
   localparam logic [39:0] CYC_MIN = 40'(`PSC_CYC_PER_MIN - 1);
   always_comb begin
      cyc_nxt = cyc_r;
      min_nxt = min_r;
      exp_nxt = 1'b0;
      if (lnk.clear || !lnk.enable) begin
         cyc_nxt = 40'h0;
         min_nxt = 16'h0;
      end else if (cyc_r == CYC_MIN) begin
         cyc_nxt = 40'h0;
         min_nxt = min_r + 16'h1;
      end else begin
         cyc_nxt = cyc_r + 40'h1;
      end
      if (lnk.enable && !lnk.clear && min_r >= lnk.minutes)
         exp_nxt = 1'b1;
   end
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cyc_r <= 40'h0;
         min_r <= 16'h0;
         exp_r <= 1'b0;
      end else begin
         cyc_r <= cyc_nxt;
         min_r <= min_nxt;
         exp_r <= exp_nxt;
      end
   end
   assign lnk.expired = exp_r;
endmodule

// >>> testbench/formatter_model.sv
// Formatter model issuing commands and gating image data
`timescale 1ns/1ps
module formatter_model (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_go_print,
   input wire logic i_go_sleep,
   input wire logic i_go_calib,
   input wire logic i_image_req,
   output logic o_print_cmd,
   output logic o_sleep_cmd,
   output logic o_calib_cmd,
   output logic o_data_valid
);
   // ----------------------------------------
   // Commands and image data
   // ----------------------------------------
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_print_cmd <= 1'b0;
         o_sleep_cmd <= 1'b0;
         o_calib_cmd <= 1'b0;
         o_data_valid <= 1'b0;
      end else begin
         o_print_cmd <= i_go_print;
         o_sleep_cmd <= i_go_sleep;
         o_calib_cmd <= i_go_calib;
         // Never stream ahead of the engine's request
         o_data_valid <= i_image_req;
      end
   end
endmodule

// >>> testbench/print_sequence_controller_test.sv
// Self-checking bench for the print sequence controller
`timescale 1ns/1ps
module print_sequence_controller_test;
   import psc_pkg::*;
   // ----------------------------------------
   // Stimulus and observation
   // ----------------------------------------
   logic i_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic door = 1'b1, rdy = 1'b0, cdone = 1'b0, pick = 1'b0, fused = 1'b0;
   logic stop = 1'b0, synced = 1'b0, slp_en = 1'b1, wake = 1'b0;
   logic err = 1'b0, go_p = 1'b0, go_s = 1'b0, go_c = 1'b0;
   logic pc, sc, cc, dv;
   logic [15:0] minutes = 16'h0001;
   logic [2:0] period;
   wire logic [6:0] act;
   wire logic [3:0] warm;
   wire logic [4:0] misc;
   int n_errors = 0;
   int n_tests = 0;
   logic [31:0] seed = 32'h0156600E;
   always #25 i_clk = ~i_clk;
   formatter_model fmt (.i_clk(i_clk), .i_nrst(i_nrst), .i_go_print(go_p),
      .i_go_sleep(go_s), .i_go_calib(go_c), .i_image_req(misc[3]),
      .o_print_cmd(pc), .o_sleep_cmd(sc), .o_calib_cmd(cc),
      .o_data_valid(dv));
   print_sequence_controller uut (.i_clk(i_clk), .i_nrst(i_nrst),
      .i_door_closed(door), .i_engine_ready(rdy), .i_print_cmd(pc),
      .i_sleep_cmd(sc), .i_calib_cmd(cc), .i_calib_done(cdone),
      .i_first_pick(pick), .i_last_fused(fused), .i_motor_stopped(stop),
      .i_image_synced(synced), .i_sleep_enable(slp_en),
      .i_sleep_minutes(minutes), .i_wake_event(wake),
      .i_error_active(err), .o_period(period), .o_fuser_heat(warm[3]),
      .o_detect_parts(warm[2]), .o_home_belt(warm[1]),
      .o_clean_toner(warm[0]), .o_hv_on(act[6]), .o_scanner_on(act[5]),
      .o_shutter_open(act[4]), .o_clean_window(act[3]),
      .o_cart_engaged(act[2]), .o_form_image(act[1]), .o_deliver(act[0]),
      .o_calibrating(misc[4]), .o_image_req(misc[3]),
      .o_backlight_on(misc[2]), .o_show_sleep(misc[1]),
      .o_show_error(misc[0]));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] xs(logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   // Actuators {hv, scanner, shutter, window, carts, form, deliver}
   function automatic logic [6:0] exp_act(logic [2:0] p);
      case (p)
         ST_INIT_ROT: return 7'h7C;
         ST_PRINTING: return 7'h76;
         ST_LAST_ROT: return 7'h09;
         default: return 7'h00;
      endcase
   endfunction
   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(negedge i_clk);
   endtask
   task automatic hit(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
      cyc(2);
   endtask
   // Random dwell; a nonzero minute count can never expire in this run
   task automatic dwell();
      seed = xs(seed);
      minutes = {8'h00, seed[7:0] | 8'h01};
      cyc(2 + int'(seed[10:8]));
   endtask
   task automatic expect_p(logic [2:0] p);
      chk("period", {5'h00, p}, {5'h00, period});
      chk("actuators", {1'b0, exp_act(p)}, {1'b0, act});
   endtask
   task automatic tally_and_finish();
      $display("Checks %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      #(50 * 5000);
      n_errors++;
      tally_and_finish();
   end
   initial begin
      cyc(12);
      i_nrst = 1'b1;
      expect_p(ST_WARMUP);
      chk("warmup_jobs", 8'h0F, {4'h0, warm});
      dwell();
      hit(rdy);
      expect_p(ST_STANDBY);
      hit(go_p);
      for (int k = 0; k < 2; k++) begin
         expect_p(ST_INIT_ROT);
         hit(pick);
         expect_p(ST_PRINTING);
         chk("image_req", 8'h00, {7'h00, misc[3]});
         dwell();
         synced = 1'b1;
         cyc(3);
         chk("data_valid", 8'h01, {7'h00, dv});
         synced = 1'b0;
         hit(fused);
         expect_p(ST_LAST_ROT);
         if (k == 0) begin
            hit(go_p);
         end
         hit(stop);
         expect_p(k == 0 ? ST_INIT_ROT : ST_STANDBY);
      end
      hit(go_c);
      chk("calibrating", 8'h01, {7'h00, misc[4]});
      hit(cdone);
      chk("calib_end", 8'h00, {7'h00, misc[4]});
      hit(go_s);
      expect_p(ST_SLEEP);
      chk("display", 8'h02, {5'h00, misc[2:0]});
      err = 1'b1;
      cyc(2);
      chk("display_err", 8'h01, {5'h00, misc[2:0]});
      err = 1'b0;
      hit(wake);
      expect_p(ST_WARMUP);
      hit(rdy);
      minutes = 16'h0000;
      cyc(6);
      expect_p(ST_SLEEP);
      door = 1'b0;
      cyc(2);
      door = 1'b1;
      cyc(2);
      expect_p(ST_WARMUP);
      tally_and_finish();
   end
endmodule
